// *** src/cfgb_pkg.sv ***
// Package for the drive, power and auxiliary decode configuration register bank.
package cfgb_pkg;

	// Register indices as seen through the configuration index register
	localparam logic [7:0] CFGB_IDX_DRIVE_TYPE_IDS = 8'h06;
	localparam logic [7:0] CFGB_IDX_POWER_AND_BOOT = 8'h07;
	localparam logic [7:0] CFGB_IDX_AUX_DECODE_LOW = 8'h08;
	localparam logic [7:0] CFGB_IDX_AUX_DECODE_HIGH = 8'h09;
	localparam logic [7:0] CFGB_IDX_ECP_IR = 8'h0A;
	localparam logic [7:0] CFGB_IDX_DRIVE_RATE = 8'h0B;

	// Reset values
	localparam logic [7:0] CFGB_RST_DRIVE_TYPE_IDS = 8'hFF;
	localparam logic [7:0] CFGB_RST_POWER_AND_BOOT = 8'h00;
	localparam logic [7:0] CFGB_RST_AUX_DECODE_LOW = 8'h00;
	localparam logic [7:0] CFGB_RST_AUX_DECODE_HIGH = 8'h00;
	localparam logic [7:0] CFGB_RST_ECP_IR = 8'h00;
	localparam logic [7:0] CFGB_RST_DRIVE_RATE = 8'h00;

	// Writable bits; the rest are reserved, ignore writes and read as zero
	localparam logic [7:0] CFGB_WMASK_DRIVE_TYPE_IDS = 8'hFF;
	localparam logic [7:0] CFGB_WMASK_POWER_AND_BOOT = 8'hF3;
	localparam logic [7:0] CFGB_WMASK_AUX_DECODE_LOW = 8'hF0;
	localparam logic [7:0] CFGB_WMASK_AUX_DECODE_HIGH = 8'hCF;
	localparam logic [7:0] CFGB_WMASK_ECP_IR = 8'hCF;
	localparam logic [7:0] CFGB_WMASK_DRIVE_RATE = 8'hFF;

	// Field positions
	localparam int CFGB_POS_BOOT_DRIVE = 0;
	localparam int CFGB_POS_PWRDN = 4;
	localparam int CFGB_POS_AUX_LOW = 4;
	localparam int CFGB_POS_AUX_HIGH = 0;
	localparam int CFGB_POS_AUX_CFG = 6;
	localparam int CFGB_POS_ECP_THRESHOLD = 0;
	localparam int CFGB_POS_IR_ROUTE = 6;
	localparam int CFGB_NUM_DRIVES = 4;

	// Auxiliary decoder configuration codes
	typedef enum logic [1:0] {
		CFGB_AUX_OFF = 2'h0,
		CFGB_AUX_BYTE = 2'h1,
		CFGB_AUX_BLOCK8 = 2'h2,
		CFGB_AUX_BLOCK16 = 2'h3
	} cfgb_aux_mode_t;

	// Infrared pin routing codes
	typedef enum logic [1:0] {
		CFGB_IR_PRIMARY = 2'h0,
		CFGB_IR_SECONDARY = 2'h1,
		CFGB_IR_RESERVED = 2'h2,
		CFGB_IR_TX_OFF = 2'h3
	} cfgb_ir_route_t;

	// One host access to the bank
	typedef struct packed {
		logic cfg_mode;
		logic [7:0] index;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} cfgb_host_req_t;

	// Automatic power-down enables
	typedef struct packed {
		logic floppy;
		logic uart1;
		logic uart2;
		logic parallel;
	} cfgb_pwrdn_t;

endpackage

// *** src/cfgb_regs.sv ***
// Drive type, boot and power-down, auxiliary decode, ECP threshold, IR route and rate registers.
//
// What this block does
// R1 - Registers 06h-0Bh accessible only in configuration state with matching index.
// R2 - Drive type register resets to FFh; drive n uses bits 2n+1:2n.
// R3 - Boot field bits 1:0 selects drive A at 0, B at 1; resets 00h.
// R4 - Power register bits 2 and 3 always read zero.
// R5 - Bits 4..7 enable auto power-down: parallel, UART2, UART1, floppy; default off.
// R6 - Power-down enables clear on power-on or hardware reset.
// R7 - Low aux register holds address bits 7:4 high; low nibble reads zero.
// R8 - High aux register holds address bits 11:8 and control bits 7:6.
// R9 - Chip select only when address 11:4 matches and 15:12 are zero.
// R10 - Control 00 off, 01 byte, 10 eight-byte block, 11 sixteen-byte block.
// R11 - ECP register bits 3:0 hold FIFO threshold; resets 00h.
// R12 - ECP register bits 5:4 not writable, read zero.
// R13 - Infrared route field clears on power-on or hardware reset.
// R14 - Route 00 primary, 01 secondary, 10 reserved, 11 both transmitters off.
// R15 - Rate select register holds two bits per drive; resets 00h.
// R16 - Chip select stays high when disabled, unmatched or no I/O cycle.
`timescale 1ns/100ps
module cfgb_regs (
	input wire logic sys_clk_i, // 50 MHz clock
	input wire logic rst_i, // Power-on or hardware reset, sync, high
	input wire cfgb_pkg::cfgb_host_req_t host_req_i, // Host access via index register
	output logic bank_hit_o, // This bank owns the current index
	output logic [7:0] rdata_o, // Read data, registered
	output logic rd_ack_o, // Read data valid, one cycle
	input wire logic [15:0] sys_addr_i, // System I/O address
	input wire logic io_cycle_i, // I/O cycle in progress
	output logic aux_chip_select_n_o, // Auxiliary chip select, low active
	output logic [7:0] drive_type_code_o, // Two bits per drive
	output logic [1:0] boot_drive_o, // 0 drive A, 1 drive B
	output cfgb_pkg::cfgb_pwrdn_t pwrdn_en_o, // Auto power-down enables
	output logic [3:0] ecp_fifo_threshold_o, // ECP FIFO threshold
	output logic [7:0] rate_table_sel_o, // Two bits per drive
	output logic [1:0] infrared_pin_route_o, // Current routing code
	input wire logic infrared_tx_i, // Transmit data from IR controller
	output logic infrared_rx_o, // Receive data to IR controller
	input wire logic infrared_rx_primary_i, // Primary receive pin
	input wire logic infrared_rx_secondary_i, // Secondary receive pin
	output logic infrared_tx_primary_o, // Primary transmit pin value
	output logic infrared_tx_primary_oe_n_o, // Low while driving primary
	output logic infrared_tx_secondary_o, // Secondary transmit pin value
	output logic infrared_tx_secondary_oe_n_o // Low while driving secondary
);
	import cfgb_pkg::*;

	function automatic logic idx_is(input cfgb_host_req_t req, input logic [7:0] idx);
		idx_is = req.cfg_mode && (req.index == idx);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	logic [7:0] drive_type_q;
	logic [7:0] drive_type_d;
	logic [7:0] power_boot_q;
	logic [7:0] power_boot_d;
	logic [7:0] aux_low_q;
	logic [7:0] aux_low_d;
	logic [7:0] aux_high_q;
	logic [7:0] aux_high_d;
	logic [7:0] ecp_ir_q;
	logic [7:0] ecp_ir_d;
	logic [7:0] drive_rate_q;
	logic [7:0] drive_rate_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic rd_ack_q;
	logic cs_n_q;
	logic cs_n_d;

	wire sel_type = idx_is(host_req_i, CFGB_IDX_DRIVE_TYPE_IDS); // [R1]
	wire sel_power = idx_is(host_req_i, CFGB_IDX_POWER_AND_BOOT); // [R1]
	wire sel_aux_lo = idx_is(host_req_i, CFGB_IDX_AUX_DECODE_LOW); // [R1]
	wire sel_aux_hi = idx_is(host_req_i, CFGB_IDX_AUX_DECODE_HIGH); // [R1]
	wire sel_ecp = idx_is(host_req_i, CFGB_IDX_ECP_IR); // [R1]
	wire sel_rate = idx_is(host_req_i, CFGB_IDX_DRIVE_RATE); // [R1]
	wire any_sel = sel_type | sel_power | sel_aux_lo | sel_aux_hi | sel_ecp | sel_rate;
	wire wr_go = host_req_i.wr;
	wire [7:0] wd = host_req_i.wdata;

	assign bank_hit_o = any_sel;

	// Reserved bits are masked on write so they can never hold a one
	assign drive_type_d = (wr_go && sel_type) ?
		merge(drive_type_q, wd, CFGB_WMASK_DRIVE_TYPE_IDS) : drive_type_q; // [R2]
	assign power_boot_d = (wr_go && sel_power) ?
		merge(power_boot_q, wd, CFGB_WMASK_POWER_AND_BOOT) : power_boot_q; // [R3] [R4] [R5]
	assign aux_low_d = (wr_go && sel_aux_lo) ?
		merge(aux_low_q, wd, CFGB_WMASK_AUX_DECODE_LOW) : aux_low_q; // [R7]
	assign aux_high_d = (wr_go && sel_aux_hi) ?
		merge(aux_high_q, wd, CFGB_WMASK_AUX_DECODE_HIGH) : aux_high_q; // [R8]
	assign ecp_ir_d = (wr_go && sel_ecp) ?
		merge(ecp_ir_q, wd, CFGB_WMASK_ECP_IR) : ecp_ir_q; // [R11] [R12]
	assign drive_rate_d = (wr_go && sel_rate) ?
		merge(drive_rate_q, wd, CFGB_WMASK_DRIVE_RATE) : drive_rate_q; // [R15]

	// One reset input serves both power-on and hardware reset
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			drive_type_q <= CFGB_RST_DRIVE_TYPE_IDS; // [R2]
			power_boot_q <= CFGB_RST_POWER_AND_BOOT; // [R3] [R6]
			aux_low_q <= CFGB_RST_AUX_DECODE_LOW; // [R7]
			aux_high_q <= CFGB_RST_AUX_DECODE_HIGH; // [R8]
			ecp_ir_q <= CFGB_RST_ECP_IR; // [R11] [R13]
			drive_rate_q <= CFGB_RST_DRIVE_RATE; // [R15]
		end else begin
			drive_type_q <= drive_type_d;
			power_boot_q <= power_boot_d;
			aux_low_q <= aux_low_d;
			aux_high_q <= aux_high_d;
			ecp_ir_q <= ecp_ir_d;
			drive_rate_q <= drive_rate_d;
		end
	end

	// Read path; masking again keeps reserved bits zero on readback
	always_comb begin
		rdata_d = 8'h00;
		if (sel_type) begin
			rdata_d = drive_type_q & CFGB_WMASK_DRIVE_TYPE_IDS;
		end
		if (sel_power) begin
			rdata_d = power_boot_q & CFGB_WMASK_POWER_AND_BOOT; // [R4]
		end
		if (sel_aux_lo) begin
			rdata_d = aux_low_q & CFGB_WMASK_AUX_DECODE_LOW; // [R7]
		end
		if (sel_aux_hi) begin
			rdata_d = aux_high_q & CFGB_WMASK_AUX_DECODE_HIGH;
		end
		if (sel_ecp) begin
			rdata_d = ecp_ir_q & CFGB_WMASK_ECP_IR; // [R12]
		end
		if (sel_rate) begin
			rdata_d = drive_rate_q & CFGB_WMASK_DRIVE_RATE;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
			rd_ack_q <= 1'b0;
		end else begin
			rdata_q <= (host_req_i.rd && any_sel) ? rdata_d : 8'h00; // [R1]
			rd_ack_q <= host_req_i.rd && any_sel;
		end
	end

	assign rdata_o = rdata_q;
	assign rd_ack_o = rd_ack_q;

	// Per-drive fields, drive n in bits 2n+1:2n
	genvar gi;
	generate
		for (gi = 0; gi < CFGB_NUM_DRIVES; gi++) begin : g_drive
			assign drive_type_code_o[2*gi+1:2*gi] = drive_type_q[2*gi+1:2*gi]; // [R2]
			assign rate_table_sel_o[2*gi+1:2*gi] = drive_rate_q[2*gi+1:2*gi]; // [R15]
		end
	endgenerate

	assign boot_drive_o = power_boot_q[CFGB_POS_BOOT_DRIVE+:2]; // [R3]
	assign pwrdn_en_o = cfgb_pwrdn_t'(power_boot_q[CFGB_POS_PWRDN+:4]); // [R5]
	assign ecp_fifo_threshold_o = ecp_ir_q[CFGB_POS_ECP_THRESHOLD+:4]; // [R11]

	// Auxiliary address decoder
	wire [3:0] aux_addr_low_bits = aux_low_q[CFGB_POS_AUX_LOW+:4];
	wire [3:0] aux_addr_high_bits = aux_high_q[CFGB_POS_AUX_HIGH+:4];
	wire cfgb_aux_mode_t aux_mode = cfgb_aux_mode_t'(aux_high_q[CFGB_POS_AUX_CFG+:2]);
	wire upper_zero = (sys_addr_i[15:12] == 4'h0); // [R9]
	wire base_match = upper_zero && (sys_addr_i[11:8] == aux_addr_high_bits)
		&& (sys_addr_i[7:4] == aux_addr_low_bits); // [R9]
	logic low_ok;

	always_comb begin
		low_ok = 1'b0;
		unique case (aux_mode)
			CFGB_AUX_OFF: low_ok = 1'b0; // [R10]
			CFGB_AUX_BYTE: low_ok = (sys_addr_i[3:0] == 4'h0); // [R10]
			CFGB_AUX_BLOCK8: low_ok = ~sys_addr_i[3]; // [R10]
			CFGB_AUX_BLOCK16: low_ok = 1'b1; // [R10]
		endcase
	end

	// Registered so the select cannot glitch while the address settles
	assign cs_n_d = ~(io_cycle_i && base_match && low_ok); // [R16]

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cs_n_q <= 1'b1;
		end else begin
			cs_n_q <= cs_n_d;
		end
	end

	assign aux_chip_select_n_o = cs_n_q;

	// Infrared pin routing
	wire cfgb_ir_route_t ir_route = cfgb_ir_route_t'(ecp_ir_q[CFGB_POS_IR_ROUTE+:2]);
	logic tx_pri_oe_n;
	logic tx_sec_oe_n;
	logic rx_sel_secondary;

	// Reserved code behaves as the primary pair, the least surprising fallback
	always_comb begin
		tx_pri_oe_n = 1'b1;
		tx_sec_oe_n = 1'b1;
		rx_sel_secondary = 1'b0;
		unique case (ir_route)
			CFGB_IR_PRIMARY: tx_pri_oe_n = 1'b0; // [R14]
			CFGB_IR_SECONDARY: begin
				tx_sec_oe_n = 1'b0; // [R14]
				rx_sel_secondary = 1'b1;
			end
			CFGB_IR_RESERVED: tx_pri_oe_n = 1'b0;
			CFGB_IR_TX_OFF: begin
				tx_pri_oe_n = 1'b1; // [R14]
				tx_sec_oe_n = 1'b1;
			end
		endcase
	end

	assign infrared_pin_route_o = ecp_ir_q[CFGB_POS_IR_ROUTE+:2];
	assign infrared_tx_primary_o = infrared_tx_i;
	assign infrared_tx_secondary_o = infrared_tx_i;
	assign infrared_tx_primary_oe_n_o = tx_pri_oe_n;
	assign infrared_tx_secondary_oe_n_o = tx_sec_oe_n;
	assign infrared_rx_o = rx_sel_secondary ? infrared_rx_secondary_i : infrared_rx_primary_i;

endmodule

// *** sim/cfgb_regs_chk.sv ***
// Port-level assertions for the configuration register bank.
`timescale 1ns/100ps
module cfgb_regs_chk (
	input wire logic sys_clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire cfgb_pkg::cfgb_host_req_t host_req_i, // Access
	input wire logic bank_hit_o, // Hit
	input wire logic [7:0] rdata_o, // Data
	input wire logic rd_ack_o, // Ack
	input wire logic [15:0] sys_addr_i, // Address
	input wire logic io_cycle_i, // Cycle
	input wire logic aux_chip_select_n_o, // Select
	input wire logic [7:0] drive_type_code_o, // Types
	input wire cfgb_pkg::cfgb_pwrdn_t pwrdn_en_o, // Enables
	input wire logic [1:0] infrared_pin_route_o, // Route
	input wire logic infrared_tx_primary_oe_n_o, // Enable
	input wire logic infrared_tx_secondary_oe_n_o // Enable
);
	import cfgb_pkg::*;
	wire logic rd_hit = host_req_i.rd && bank_hit_o;
	wire logic [7:0] idx = host_req_i.index;
	wire logic [7:0] wd = host_req_i.wdata;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	a_hit_decode: assert property (
		bank_hit_o == (host_req_i.cfg_mode && idx >= 8'h06 && idx <= 8'h0B))
		else $error("bank hit wrong");
	a_read_ack: assert property (rd_hit |=> rd_ack_o)
		else $error("read without ack");
	a_no_stray: assert property (!rd_hit |=> !rd_ack_o && rdata_o == 8'h00)
		else $error("stray ack or data");
	a_pwr_rsvd: assert property (rd_hit && idx == 8'h07 |=> rdata_o[3:2] == 2'h0)
		else $error("power reserved bits set");
	a_ecp_rsvd: assert property (rd_hit && idx == 8'h0A |=> rdata_o[5:4] == 2'h0)
		else $error("ECP reserved bits set");
	a_type_write: assert property (
		host_req_i.wr && bank_hit_o && idx == 8'h06 |=> drive_type_code_o == $past(wd))
		else $error("drive type write lost");
	a_cs_idle: assert property (!io_cycle_i |=> aux_chip_select_n_o)
		else $error("select without cycle");
	a_cs_upper: assert property (sys_addr_i[15:12] != 4'h0 |=> aux_chip_select_n_o)
		else $error("select with high address");
	a_ir_off: assert property (infrared_pin_route_o == 2'h3 |->
		infrared_tx_primary_oe_n_o && infrared_tx_secondary_oe_n_o)
		else $error("transmit driven when off");
	a_reset_vals: assert property (disable iff (1'b0) rst_i |=>
		drive_type_code_o == 8'hFF && pwrdn_en_o == '0 && infrared_pin_route_o == 2'h0)
		else $error("reset values wrong");
	c_read: cover property (rd_ack_o);
	c_select: cover property (!aux_chip_select_n_o);
	c_second: cover property (infrared_pin_route_o == 2'h1);
endmodule
bind cfgb_regs cfgb_regs_chk cfgb_regs_chk_inst (.sys_clk_i, .rst_i, .host_req_i, .bank_hit_o,
	.rdata_o, .rd_ack_o, .sys_addr_i, .io_cycle_i, .aux_chip_select_n_o, .drive_type_code_o,
	.pwrdn_en_o, .infrared_pin_route_o, .infrared_tx_primary_oe_n_o, .infrared_tx_secondary_oe_n_o);

// *** sim/cfgb_host_model.sv ***
// Host processor model issuing configuration accesses.
`timescale 1ns/100ps
module cfgb_host_model (
	input wire logic sys_clk_i, // Clock
	input wire logic rd_ack_i, // Read ack
	input wire logic [7:0] rdata_i, // Read data
	output cfgb_pkg::cfgb_host_req_t host_req_o // Request
);
	import cfgb_pkg::*;
	initial host_req_o = '0;
	// Idle write data is inverted so a stale byte is never mistaken for a fresh one
	task automatic acc(input logic cfg, input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic ack, output logic [7:0] q);
		@(posedge sys_clk_i);
		#1;
		host_req_o.cfg_mode = cfg;
		host_req_o.index = idx;
		host_req_o.wr = w;
		host_req_o.rd = !w;
		host_req_o.wdata = d;
		@(posedge sys_clk_i);
		#1;
		ack = rd_ack_i;
		q = rdata_i;
		host_req_o.wr = 1'b0;
		host_req_o.rd = 1'b0;
		host_req_o.wdata = ~d;
	endtask
endmodule

// *** sim/tb_config_regs_drive_power_decode.sv ***
// Self-checking bench for the configuration register bank.
`timescale 1ns/100ps
module tb_config_regs_drive_power_decode;
	import cfgb_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] sys_addr_i = 16'h0000;
	logic io_cycle_i = 1'b0;
	logic infrared_tx_i = 1'b0, infrared_rx_primary_i = 1'b0, infrared_rx_secondary_i = 1'b0;
	cfgb_host_req_t host_req_i;
	cfgb_pwrdn_t pwrdn_en_o;
	logic bank_hit_o, rd_ack_o, aux_chip_select_n_o, infrared_rx_o;
	logic infrared_tx_primary_o, infrared_tx_primary_oe_n_o;
	logic infrared_tx_secondary_o, infrared_tx_secondary_oe_n_o;
	logic [7:0] rdata_o, drive_type_code_o, rate_table_sel_o;
	logic [1:0] boot_drive_o, infrared_pin_route_o;
	logic [3:0] ecp_fifo_threshold_o;
	int fails = 0, comparisons = 0, cycles = 0;
	int mdl [6] = '{8'hFF, 0, 0, 0, 0, 0};
	int wm [6] = '{8'hFF, 8'hF3, 8'hF0, 8'hCF, 8'hCF, 8'hFF};
	cfgb_regs cfgb_regs_inst (.sys_clk_i, .rst_i, .host_req_i, .bank_hit_o, .rdata_o, .rd_ack_o,
		.sys_addr_i, .io_cycle_i, .aux_chip_select_n_o, .drive_type_code_o, .boot_drive_o,
		.pwrdn_en_o, .ecp_fifo_threshold_o, .rate_table_sel_o, .infrared_pin_route_o,
		.infrared_tx_i, .infrared_rx_o, .infrared_rx_primary_i, .infrared_rx_secondary_i,
		.infrared_tx_primary_o, .infrared_tx_primary_oe_n_o, .infrared_tx_secondary_o,
		.infrared_tx_secondary_oe_n_o);
	cfgb_host_model cfgb_host_model_inst (.sys_clk_i, .rd_ack_i(rd_ack_o), .rdata_i(rdata_o),
		.host_req_o(host_req_i));
	initial forever #10 sys_clk_i = ~sys_clk_i;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic rdc(input int i);
		logic a;
		logic [7:0] q;
		cfgb_host_model_inst.acc(1'b1, 1'b0, 8'(i + 6), 8'h00, a, q);
		chk({a, q}, {1'b1, 8'(mdl[i])});
		chk(bank_hit_o, 1'b1);
	endtask
	task automatic wrm(input int i, input logic [7:0] d);
		logic a;
		logic [7:0] q;
		cfgb_host_model_inst.acc(1'b1, 1'b1, 8'(i + 6), d, a, q);
		mdl[i] = d & wm[i];
	endtask
	task automatic fields;
		chk(drive_type_code_o, mdl[0]);
		chk({pwrdn_en_o, boot_drive_o}, {mdl[1][7:4], mdl[1][1:0]});
		chk({infrared_pin_route_o, ecp_fifo_threshold_o}, {mdl[4][7:6], mdl[4][3:0]});
		chk(rate_table_sel_o, mdl[5]);
	endtask
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		logic a, e;
		logic [7:0] q;
		void'($urandom(71));
		repeat (20) @(posedge sys_clk_i);
		#1 rst_i = 1'b0;
		for (int i = 0; i < 6; i++) rdc(i);
		fields();
		repeat (4) begin
			for (int i = 0; i < 6; i++) wrm(i, 8'($urandom));
			fields();
			for (int i = 0; i < 6; i++) rdc(i);
		end
		cfgb_host_model_inst.acc(1'b0, 1'b1, 8'h07, 8'hFF, a, q);
		cfgb_host_model_inst.acc(1'b1, 1'b0, 8'h0C, 8'h00, a, q);
		chk({a, q}, 9'h000);
		chk(bank_hit_o, 1'b0);
		rdc(1);
		for (int m = 0; m < 4; m++) begin
			wrm(2, 8'($urandom));
			wrm(3, 8'({m[1:0], 6'($urandom)}));
			for (int k = 0; k < 7; k++) begin
				sys_addr_i = {4'(k == 6), 4'(mdl[3]), 4'(mdl[2] >> 4) ^ 4'(k == 5), 4'(k * 4)};
				io_cycle_i = (k != 4);
				e = k < 4 && (m == 3 || (m == 2 && !sys_addr_i[3]) || (m == 1 && k == 0));
				@(posedge sys_clk_i);
				#1;
				chk(aux_chip_select_n_o, !e);
			end
		end
		io_cycle_i = 1'b0;
		for (int r = 0; r < 4; r++) begin
			wrm(4, 8'({r[1:0], 6'($urandom)}));
			{infrared_tx_i, infrared_rx_primary_i, infrared_rx_secondary_i} = 3'($urandom);
			#1;
			chk({infrared_tx_primary_oe_n_o, infrared_tx_secondary_oe_n_o},
				{r == 1 || r == 3, r != 1});
			chk(infrared_rx_o, r == 1 ? infrared_rx_secondary_i : infrared_rx_primary_i);
			chk({infrared_tx_primary_o, infrared_tx_secondary_o}, {2{infrared_tx_i}});
		end
		wrm(1, 8'hF0);
		wrm(4, 8'hC0);
		rst_i = 1'b1;
		@(posedge sys_clk_i);
		#1 rst_i = 1'b0;
		mdl = '{8'hFF, 0, 0, 0, 0, 0};
		fields();
		wrap_up();
	end
endmodule
